// ---- include/ecp_pkg.sv ----
// constants shared by the capability parser design files
package ecp_pkg;
	// register byte offsets on the APB bus
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_ADDR   = 8'h08;
	localparam logic [7:0] REG_DATA   = 8'h0C;
	localparam logic [7:0] REG_VDB    = 8'h10;
	// control and status bit positions
	localparam int CTRL_START   = 0;
	localparam int CTRL_DDCEN   = 1;
	localparam int ST_BUSY      = 0;
	localparam int ST_PASS      = 1;
	localparam int ST_ERRBASE   = 2;
	localparam int ST_ERREXT    = 3;
	localparam int ST_ERROLDEXT = 4;
	localparam int ST_ERRNOVDB  = 5;
	localparam int ST_ERRLEN    = 6;
	localparam int ST_ERRID     = 7;
	// capability structure byte offsets and values
	localparam logic [7:0] OFF_BASE_VER  = 8'h12;
	localparam logic [7:0] OFF_BASE_REV  = 8'h13;
	localparam logic [7:0] OFF_EXT_COUNT = 8'h7E;
	localparam logic [7:0] OFF_EXT_TAG   = 8'h80;
	localparam logic [7:0] OFF_EXT_REV   = 8'h81;
	localparam logic [7:0] OFF_EXT_DOFF  = 8'h82;
	localparam logic [8:0] OFF_EXT_BLKS  = 9'h084;
	localparam logic [7:0] BASE_VER      = 8'h01;
	localparam logic [7:0] BASE_REV      = 8'h03;
	localparam logic [7:0] EXT_TAG       = 8'h02;
	localparam logic [7:0] EXT_REV       = 8'h03;
	localparam logic [2:0] VDB_TAG       = 3'h3;
	localparam logic [4:0] VDB_LEN_MIN   = 5'h05;
	localparam logic [4:0] VDB_LEN_MAX   = 5'h1F;
	localparam logic [7:0] DDC_IDLE_BYTE = 8'hFF;
	localparam int         MEM_DEPTH     = 256;
	localparam int         SCAN_LIMIT    = 600;
endpackage

// ---- design/ecp_byte_mem.sv ----
// capability byte store: one write port, two registered read ports
`timescale 1ns/1ps
`default_nettype none
module ecp_byte_mem #(
	parameter int DEPTH = 256,
	parameter int AW    = 8
) (
	input  wire logic          clk,
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [7:0]    wrData,
	input  wire logic [AW-1:0] rdAddrA,
	output logic      [7:0]    rdDataA,
	input  wire logic [AW-1:0] rdAddrB,
	output logic      [7:0]    rdDataB
);
	logic [7:0] mem [DEPTH];

	// contents are not reset: software loads the structure after power-up
	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clk) begin
		rdDataA <= mem[rdAddrA];
		rdDataB <= mem[rdAddrB];
	end
endmodule
`default_nettype wire

// ---- design/ecp_capability_store.sv ----
// sink capability store with channel read port and structure checker
// Functional notes
// RULE1 - sink holds a capability structure readable over the data channel
// RULE2 - source reads base block and first extension to learn features
// RULE3 - source may read further extension blocks too
// RULE4 - source keeps link clock within sink maximum and clock field
// RULE5 - first 128 bytes form a version 1.3 base block
// RULE6 - first extension is consumer extension version 3
// RULE7 - no consumer extension of version 1 or 2 anywhere; the checker tests only the first extension's revision
// RULE8 - first extension holds vendor block with 24-bit registration id
// RULE9 - vendor block carries 2-byte physical address right after the id
// RULE10 - vendor block length lies between 5 and 31
// RULE11 - length covers every extension field the sink supports
// RULE12 - source parser accepts a vendor block of any length
// RULE13 - source should use length to find present extension fields
// RULE14 - source ignores non-zero reserved fields
// RULE15 - source treats fields past the length as zero
// RULE16 - vendor block byte 0 holds tag code 3 and length
// RULE17 - source may send basic audio; other conversion is its duty
// RULE18 - tag in bits 7 to 5, length in bits 4 to 0
`timescale 1ns/1ps
`default_nettype none
module ecp_capability_store
	import ecp_pkg::*;
#(
	parameter logic [23:0] VENDOR_ID = 24'h5A_A5_C3 // arbitrary value
) (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  ddcAddr,
	output logic      [7:0]  ddcData
);
	typedef enum {S_IDLE, S_VER, S_REV, S_EXTN, S_ETAG, S_EREV, S_DOFF,
		S_HDR, S_ID0, S_ID1, S_ID2, S_PA0, S_PA1} ecp_state_t;

	logic       rstSync1_q, rstSyncN_q;
	logic       ddcEn_q, busy_q, phase_q;
	logic [7:0] errs_q, addr_q, dOff_q, vdbBase_q;
	logic [8:0] ptr_q, hdrAddr_q;
	logic [4:0] vdbLen_q;
	logic [15:0] physAddr_q;
	ecp_state_t state_q;
	logic [7:0] chkAddr, memB, memA;
	logic       apbAcc, apbWr, mapped, startReq, dataWr;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rstSync1_q <= 1'b0;
			rstSyncN_q <= 1'b0;
		end else begin
			rstSync1_q <= 1'b1;
			rstSyncN_q <= rstSync1_q;
		end
	end

	assign apbAcc   = psel & penable;
	assign apbWr    = apbAcc & pwrite;
	assign mapped   = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
		(paddr == REG_ADDR) || (paddr == REG_DATA) || (paddr == REG_VDB);
	assign pready   = apbAcc;
	assign pslverr  = apbAcc & ~mapped;
	assign startReq = apbWr & (paddr == REG_CTRL) & pwdata[CTRL_START] &
		~busy_q;
	assign dataWr   = apbWr & (paddr == REG_DATA);

	always_comb begin
		prdata = 32'h0000_0000;
		case (paddr)
			REG_CTRL:   prdata[CTRL_DDCEN] = ddcEn_q;
			REG_STATUS: prdata = {24'h00_0000, errs_q[7:2], 1'b0, busy_q} |
				{30'h0000_0000, ~busy_q & (errs_q[7:2] == 6'h00) &
				errs_q[ST_PASS], 1'b0};
			REG_ADDR:   prdata[7:0] = addr_q;
			REG_DATA:   prdata[7:0] = memB;
			REG_VDB:    prdata = {physAddr_q, 3'h0, vdbLen_q, vdbBase_q};
			default:    prdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk or negedge rstSyncN_q) begin
		if (!rstSyncN_q) begin
			ddcEn_q <= 1'b0;
		end else if (apbWr && paddr == REG_CTRL) begin
			ddcEn_q <= pwdata[CTRL_DDCEN];
		end
	end

	// byte pointer auto-increments so the structure loads as a stream
	always_ff @(posedge mclk or negedge rstSyncN_q) begin
		if (!rstSyncN_q) begin
			addr_q <= 8'h00;
		end else if (apbWr && paddr == REG_ADDR) begin
			addr_q <= pwdata[7:0];
		end else if (dataWr) begin
			addr_q <= addr_q + 8'h01;
		end
	end

	// checker owns read port B while busy; data readback returns the checker's byte then
	always_comb begin
		chkAddr = addr_q;
		case (state_q)
			S_VER:   chkAddr = OFF_BASE_VER;
			S_REV:   chkAddr = OFF_BASE_REV;
			S_EXTN:  chkAddr = OFF_EXT_COUNT;
			S_ETAG:  chkAddr = OFF_EXT_TAG;
			S_EREV:  chkAddr = OFF_EXT_REV;
			S_DOFF:  chkAddr = OFF_EXT_DOFF;
			S_IDLE:  chkAddr = addr_q;
			default: chkAddr = ptr_q[7:0];
		endcase
	end

	ecp_byte_mem #(.DEPTH(MEM_DEPTH), .AW(8)) u_mem (
		.clk     (mclk),
		.wrEn    (dataWr),
		.wrAddr  (addr_q),
		.wrData  (pwdata[7:0]),
		.rdAddrA (ddcAddr),
		.rdDataA (memA),
		.rdAddrB (chkAddr),
		.rdDataB (memB)
	);

	// channel reads answer a fixed idle byte until software enables them
	always_ff @(posedge mclk or negedge rstSyncN_q) begin
		if (!rstSyncN_q) begin
			ddcData <= DDC_IDLE_BYTE;
		end else begin
			ddcData <= ddcEn_q ? memA : DDC_IDLE_BYTE; // RULE1
		end
	end

	// each scan state takes two cycles: present address, then judge the byte
	always_ff @(posedge mclk or negedge rstSyncN_q) begin
		if (!rstSyncN_q) begin
			state_q    <= S_IDLE;
			phase_q    <= 1'b0;
			busy_q     <= 1'b0;
			errs_q     <= 8'h00;
			ptr_q      <= 9'h000;
			hdrAddr_q  <= 9'h000;
			dOff_q     <= 8'h00;
			vdbBase_q  <= 8'h00;
			vdbLen_q   <= 5'h00;
			physAddr_q <= 16'h0000;
		end else if (state_q == S_IDLE) begin
			if (startReq) begin
				state_q <= S_VER;
				busy_q  <= 1'b1;
				phase_q <= 1'b0;
				errs_q  <= 8'h00;
			end
		end else if (!phase_q) begin
			phase_q <= 1'b1;
		end else begin
			phase_q <= 1'b0;
			case (state_q)
				S_VER: begin
					errs_q[ST_ERRBASE] <= (memB != BASE_VER); // RULE5
					state_q <= S_REV;
				end
				S_REV: begin
					if (memB != BASE_REV) begin
						errs_q[ST_ERRBASE] <= 1'b1; // RULE5
					end
					state_q <= S_EXTN;
				end
				S_EXTN: begin
					if (memB == 8'h00) begin
						errs_q[ST_ERREXT] <= 1'b1; // RULE6
						state_q <= S_IDLE;
						busy_q  <= 1'b0;
					end else begin
						state_q <= S_ETAG;
					end
				end
				S_ETAG: begin
					errs_q[ST_ERREXT] <= (memB != EXT_TAG); // RULE6
					state_q <= S_EREV;
				end
				S_EREV: begin
					if (memB == 8'h01 || memB == 8'h02) begin
						errs_q[ST_ERROLDEXT] <= 1'b1; // RULE7
					end
					if (memB != EXT_REV) begin
						errs_q[ST_ERREXT] <= 1'b1; // RULE6
					end
					state_q <= S_DOFF;
				end
				S_DOFF: begin
					dOff_q  <= memB;
					ptr_q   <= OFF_EXT_BLKS;
					state_q <= S_HDR;
				end
				S_HDR: begin
					hdrAddr_q <= ptr_q;
					if (ptr_q >= {1'b0, dOff_q}) begin
						errs_q[ST_ERRNOVDB] <= 1'b1; // RULE8
						state_q <= S_IDLE;
						busy_q  <= 1'b0;
					end else if (memB[7:5] == VDB_TAG && memB[4:0] >= 5'h03) begin
						vdbLen_q <= memB[4:0]; // RULE16 RULE18
						ptr_q    <= ptr_q + 9'h001;
						state_q  <= S_ID0;
					end else begin
						ptr_q <= ptr_q + {4'h0, memB[4:0]} + 9'h001; // RULE18
					end
				end
				S_ID0, S_ID1, S_ID2: begin
					// id stored least significant byte first
					if (memB != VENDOR_ID[8*(state_q-S_ID0) +: 8]) begin
						ptr_q   <= hdrAddr_q + {4'h0, vdbLen_q} + 9'h001;
						state_q <= S_HDR;
					end else begin
						ptr_q   <= ptr_q + 9'h001;
						state_q <= ecp_state_t'(state_q + 1); // RULE8
					end
				end
				S_PA0: begin
					vdbBase_q        <= hdrAddr_q[7:0];
					physAddr_q[15:8] <= memB; // RULE9
					ptr_q            <= ptr_q + 9'h001;
					state_q          <= S_PA1;
				end
				S_PA1: begin
					physAddr_q[7:0] <= memB; // RULE9
					errs_q[ST_ERRLEN] <= (vdbLen_q < VDB_LEN_MIN) ||
						(vdbLen_q > VDB_LEN_MAX); // RULE10 RULE11
					errs_q[ST_PASS] <= 1'b1;
					state_q <= S_IDLE;
					busy_q  <= 1'b0;
				end
				default: begin
					state_q <= S_IDLE;
					busy_q  <= 1'b0;
				end
			endcase
		end
	end

	// assertions
	sequence s_startWrite;
		startReq;
	endsequence
	sequence s_idleAgain;
		!busy_q && state_q == S_IDLE;
	endsequence

	property p_startBusy;
		@(posedge mclk) disable iff (!rstSyncN_q)
		s_startWrite |=> busy_q && state_q == S_VER;
	endproperty
	a_startBusy: assert property (p_startBusy) else $error("no busy"); // RULE5

	property p_scanEnds;
		@(posedge mclk) disable iff (!rstSyncN_q)
		s_startWrite |-> ##[1:600] s_idleAgain;
	endproperty
	a_scanEnds: assert property (p_scanEnds) else $error("scan hangs"); // RULE8

	property p_ddcOff;
		@(posedge mclk) disable iff (!rstSyncN_q)
		!ddcEn_q |=> ddcData == DDC_IDLE_BYTE;
	endproperty
	a_ddcOff: assert property (p_ddcOff) else $error("ddc not idle"); // RULE1

	property p_ddcOn;
		@(posedge mclk) disable iff (!rstSyncN_q)
		ddcEn_q |=> ddcData == $past(memA);
	endproperty
	a_ddcOn: assert property (p_ddcOn) else $error("ddc data wrong"); // RULE1

	property p_lenErr;
		@(posedge mclk) disable iff (!rstSyncN_q)
		state_q == S_PA1 && phase_q && vdbLen_q < VDB_LEN_MIN
		|=> errs_q[ST_ERRLEN] && !busy_q;
	endproperty
	a_lenErr: assert property (p_lenErr) else $error("short len"); // RULE10

	property p_oldExt;
		@(posedge mclk) disable iff (!rstSyncN_q)
		state_q == S_EREV && phase_q && (memB == 8'h01 || memB == 8'h02)
		|=> errs_q[ST_ERROLDEXT] && errs_q[ST_ERREXT];
	endproperty
	a_oldExt: assert property (p_oldExt) else $error("old ext missed"); // RULE7

	property p_tagField;
		@(posedge mclk) disable iff (!rstSyncN_q)
		state_q == S_HDR && phase_q && ptr_q < {1'b0, dOff_q} &&
		memB[7:5] == VDB_TAG && memB[4:0] >= 5'h03
		|=> state_q == S_ID0 && vdbLen_q == $past(memB[4:0]);
	endproperty
	a_tagField: assert property (p_tagField) else $error("bad tag"); // RULE16

	property p_skipBlock;
		@(posedge mclk) disable iff (!rstSyncN_q)
		state_q == S_HDR && phase_q && ptr_q < {1'b0, dOff_q} &&
		memB[7:5] != VDB_TAG
		|=> ptr_q == $past(ptr_q) + {4'h0, $past(memB[4:0])} + 9'h001;
	endproperty
	a_skipBlock: assert property (p_skipBlock) else $error("bad skip"); // RULE18

	property p_unmapped;
		@(posedge mclk) disable iff (!rstSyncN_q)
		apbAcc && !mapped |-> pready && pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("no slverr"); // RULE1
endmodule
`default_nettype wire

// ---- testbench/ecp_ddc_reader.sv ----
// source-side model reading capability bytes over the channel port
`timescale 1ns/1ps
`default_nettype none
module ecp_ddc_reader (
	input  wire logic       mclk,
	input  wire logic [7:0] ddcData,
	output logic      [7:0] ddcAddr
);
	initial ddcAddr = 8'h00;
	// answer settles two edges after the address; one more edge of margin
	task automatic readByte(input logic [7:0] a,
			output logic [7:0] d);
		@(posedge mclk);
		ddcAddr <= a;
		repeat (3) @(posedge mclk);
		d = ddcData;
	endtask

	// any block length is taken; a field past the length reads as zero
	task automatic fieldByte(input logic [7:0] hdr, input logic [4:0] idx,
			input logic [7:0] keep, output logic [7:0] v);
		logic [7:0] h;
		readByte(hdr, h);
		v = 8'h00;
		if (idx <= h[4:0]) begin
			readByte(hdr + {3'h0, idx}, v);
			v = v & keep;
		end
	endtask

	// zero in the clock field means the formats alone set the limit
	task automatic clockCap(input logic [7:0] hdr, input logic [4:0] idx,
			input logic [7:0] fmtMax, output logic [7:0] cap);
		logic [7:0] maxLinkClock;
		fieldByte(hdr, idx, 8'hFF, maxLinkClock);
		cap = (maxLinkClock != 8'h00 && maxLinkClock < fmtMax) ?
			maxLinkClock : fmtMax;
	endtask
endmodule
`default_nettype wire

// ---- testbench/test_edid_capability_parser.sv ----
// self-checking bench for the capability store
`timescale 1ns/1ps
`default_nettype none
module test_edid_capability_parser;
	import ecp_pkg::*;
	logic        mclk = 1'b0;
	logic        rstn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  ddcAddr;
	logic [7:0]  ddcData;
	logic [7:0]  img [256];
	int          errBit [5] = '{ST_ERRBASE, ST_ERROLDEXT, ST_ERRLEN,
		ST_ERRNOVDB, ST_ERROLDEXT};
	int          errorCnt = 0;
	int          checked = 0;

	always #50 mclk = ~mclk;

	ecp_capability_store u_ecp_capability_store (
		.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ddcAddr(ddcAddr), .ddcData(ddcData));
	ecp_ddc_reader u_ecp_ddc_reader (
		.mclk(mclk), .ddcData(ddcData), .ddcAddr(ddcAddr));

	task automatic conclude();
		if (errorCnt == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errorCnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// video block of two bytes ahead of the vendor block tests the walk
	task automatic runCase(input logic [7:0] bRev, input logic [7:0] xRev,
			input logic [4:0] len, input logic [7:0] idLo,
			output logic [31:0] st);
		logic [31:0] r;
		logic        e;
		int          n;
		foreach (img[i]) img[i] = 8'h00;
		img[OFF_BASE_VER] = BASE_VER;
		img[OFF_BASE_REV] = bRev;
		img[OFF_EXT_COUNT] = 8'h01;
		img[OFF_EXT_TAG] = EXT_TAG;
		img[OFF_EXT_REV] = xRev;
		img[OFF_EXT_DOFF] = 8'h88 + {3'h0, len};
		img[8'h84] = 8'h42;
		img[8'h87] = {VDB_TAG, len};
		img[8'h88] = idLo;
		img[8'h89] = 8'hA5;
		img[8'h8A] = 8'h5A;
		img[8'h8B] = 8'h10;
		img[8'h8D] = 8'h96;
		apb(1'b1, REG_ADDR, 32'h0000_0000, r, e);
		for (int i = 0; i < 256; i++) begin
			apb(1'b1, REG_DATA, {24'h00_0000, img[i]}, r, e);
		end
		apb(1'b1, REG_CTRL, 32'h0000_0003, r, e);
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0000_0000, st, e);
			n++;
		end while (st[ST_BUSY] !== 1'b0 && n < 700);
		// a scan that never finishes counts against the run
		if (st[ST_BUSY] !== 1'b0) errorCnt++;
	endtask

	initial begin
		logic [31:0] st;
		logic [31:0] r;
		logic        e;
		logic [7:0]  b;
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		runCase(BASE_REV, EXT_REV, 5'h05, 8'hC3, st);
		check(st, 32'h0000_0002);
		apb(1'b0, REG_VDB, 32'h0000_0000, r, e);
		check(r, 32'h1000_0587);
		check({31'h0, e}, 32'h0000_0000);
		apb(1'b0, REG_CTRL, 32'h0000_0000, r, e);
		check(r, 32'h0000_0002);
		u_ecp_ddc_reader.readByte(8'h87, b);
		check({24'h00_0000, b}, 32'h0000_0065);
		u_ecp_ddc_reader.fieldByte(8'h87, 5'h06, 8'hFF, b);
		check({24'h00_0000, b}, 32'h0000_0000);
		u_ecp_ddc_reader.clockCap(8'h87, 5'h06, 8'hC0, b);
		check({24'h00_0000, b}, 32'h0000_00C0);
		apb(1'b1, REG_CTRL, 32'h0000_0000, r, e);
		u_ecp_ddc_reader.readByte(8'h87, b);
		check({24'h00_0000, b}, 32'h0000_00FF);
		apb(1'b0, 8'h20, 32'h0000_0000, r, e);
		check(r, 32'h0000_0000);
		check({31'h0, e}, 32'h0000_0001);
		runCase(BASE_REV, EXT_REV, 5'h1F, 8'hC3, st);
		check(st, 32'h0000_0002);
		apb(1'b0, REG_VDB, 32'h0000_0000, r, e);
		check(r, 32'h1000_1F87);
		u_ecp_ddc_reader.fieldByte(8'h87, 5'h06, 8'hF0, b);
		check({24'h00_0000, b}, 32'h0000_0090);
		u_ecp_ddc_reader.clockCap(8'h87, 5'h06, 8'hC0, b);
		check({24'h00_0000, b}, 32'h0000_0096);
		u_ecp_ddc_reader.clockCap(8'h87, 5'h06, 8'h80, b);
		check({24'h00_0000, b}, 32'h0000_0080);
		for (int k = 0; k < 5; k++) begin
			runCase(k == 0 ? 8'h04 : BASE_REV,
				k == 1 ? 8'h02 : (k == 4 ? 8'h01 : EXT_REV),
				k == 2 ? 5'h04 : 5'h05, k == 3 ? 8'hC4 : 8'hC3, st);
			check({31'h0, st[ST_PASS]}, 32'h0);
			check({31'h0, st[errBit[k]]}, 32'h1);
		end
		apb(1'b1, REG_ADDR, 32'h0000_0088, r, e);
		apb(1'b0, REG_DATA, 32'h0000_0000, r, e);
		check(r, 32'h0000_00C3);
		apb(1'b0, REG_ADDR, 32'h0000_0000, r, e);
		check(r, 32'h0000_0088);
		conclude();
	end

	// seven image loads of about 800 cycles each fit well inside this span
	initial begin
		repeat (40000) @(posedge mclk);
		errorCnt++;
		conclude();
	end
endmodule
`default_nettype wire
